// >>> design/sdram_ctrl_pkg.sv
// Shared constants and types for the SDRAM command, refresh and mapping block
package sdram_ctrl_pkg;

	localparam int ADDR_W = 8;
	localparam int MEM_ADDR_W = 28;
	localparam int ROW_W = 14;
	localparam int COL_W = 12;
	localparam int BANK_W = 2;
	localparam int BYTE_OFS_W = 2;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_COMMAND_MODE_SELECT = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_REFRESH_INTERVAL = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MEMORY_GEOMETRY_CONFIG = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_TIMING_PARAMS_A = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_TIMING_PARAMS_B = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_TIMING_PARAMS_C = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_POWER_SAVING_CONFIG = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_MEMORY_TYPE_SELECT = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_DELAY_LOOP_INFO = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_FAST_ACCESS_CONFIG = 8'h2C;
	localparam logic [ADDR_W-1:0] OFS_WRITE_LOCK_CONTROL = 8'hE4;
	localparam logic [ADDR_W-1:0] OFS_WRITE_LOCK_VIOLATION_INFO = 8'hE8;

	// Reset values
	localparam logic [31:0] RST_COMMAND_MODE_SELECT = 32'h0000_0000;
	localparam logic [31:0] RST_REFRESH_INTERVAL = 32'h0000_0000;
	localparam logic [31:0] RST_MEMORY_GEOMETRY_CONFIG = 32'h0000_7024;
	localparam logic [31:0] RST_TIMING_PARAMS_A = 32'h2022_7225;
	localparam logic [31:0] RST_TIMING_PARAMS_B = 32'h03C8_0808;
	localparam logic [31:0] RST_TIMING_PARAMS_C = 32'h0000_2062;
	localparam logic [31:0] RST_POWER_SAVING_CONFIG = 32'h0001_0000;
	localparam logic [31:0] RST_MEMORY_TYPE_SELECT = 32'h0000_0010;
	localparam logic [31:0] RST_DELAY_LOOP_INFO = 32'h0000_0001;
	localparam logic [31:0] RST_FAST_ACCESS_CONFIG = 32'h0000_0000;
	localparam logic [31:0] RST_WRITE_LOCK_CONTROL = 32'h0000_0000;

	// Field positions
	localparam int MODE_LSB = 0;
	localparam int MODE_W = 3;
	localparam int COUNT_LSB = 0;
	localparam int COUNT_W = 12;
	localparam int COL_CODE_LSB = 0;
	localparam int ROW_CODE_LSB = 2;
	localparam int GEOM_CODE_W = 2;
	localparam int LOCK_EN_BIT = 0;
	localparam int VIOL_BIT = 0;
	localparam int VIOL_SRC_LSB = 8;

	// Geometry bases: code 00 gives these many bits
	localparam int SDR_COL_BASE = 8;
	localparam int ROW_BASE = 11;

	// Refresh planning figures for software
	localparam int REFRESH_PERIOD_MS = 64;

	// Command-mode encodings
	localparam logic [MODE_W-1:0] MODE_NORMAL = 3'h0;
	localparam logic [MODE_W-1:0] MODE_NOP = 3'h1;
	localparam logic [MODE_W-1:0] MODE_PRECHARGE_ALL = 3'h2;
	localparam logic [MODE_W-1:0] MODE_LOAD_MODE = 3'h3;
	localparam logic [MODE_W-1:0] MODE_AUTO_REFRESH = 3'h4;
	localparam logic [MODE_W-1:0] MODE_EXT_LOAD_MODE = 3'h5;
	localparam logic [MODE_W-1:0] MODE_DEEP_POWER_DOWN = 3'h6;

	// Commands driven to the memory
	localparam int CMD_W = 4;
	localparam logic [CMD_W-1:0] CMD_NOP = 4'h0;
	localparam logic [CMD_W-1:0] CMD_ACTIVATE = 4'h1;
	localparam logic [CMD_W-1:0] CMD_READ = 4'h2;
	localparam logic [CMD_W-1:0] CMD_WRITE = 4'h3;
	localparam logic [CMD_W-1:0] CMD_PRECHARGE_ALL = 4'h4;
	localparam logic [CMD_W-1:0] CMD_LOAD_MODE = 4'h5;
	localparam logic [CMD_W-1:0] CMD_AUTO_REFRESH = 4'h6;
	localparam logic [CMD_W-1:0] CMD_EXT_LOAD_MODE = 4'h7;
	localparam logic [CMD_W-1:0] CMD_DEEP_POWER_DOWN = 4'h8;

	typedef enum {
		ST_IDLE,
		ST_DATA,
		ST_REFRESH
	} seq_state_t;

endpackage

// >>> design/addr_map_if.sv
// Carrier between the sequencer and the address mapper
interface addr_map_if;
	import sdram_ctrl_pkg::*;

	logic [MEM_ADDR_W-1:0]  addr;
	logic [GEOM_CODE_W-1:0] col_code;
	logic [GEOM_CODE_W-1:0] row_code;
	logic [BANK_W-1:0]      bank;
	logic [ROW_W-1:0]       row;
	logic [COL_W-1:0]       col;

	modport mapper (
		input  addr,
		input  col_code,
		input  row_code,
		output bank,
		output row,
		output col
	);

	modport user (
		output addr,
		output col_code,
		output row_code,
		input  bank,
		input  row,
		input  col
	);
endinterface

// >>> design/sdr32_addr_mapper.sv
// Splits a processor address into bank, row and column for a 32-bit SDR bus
module sdr32_addr_mapper
	import sdram_ctrl_pkg::*;
(
	addr_map_if.mapper map
);

	function automatic logic [MEM_ADDR_W-1:0] field_mask(input int width);
		field_mask = (MEM_ADDR_W)'((64'h1 << width) - 64'h1);
	endfunction

	int unsigned           col_bits;
	int unsigned           row_bits;
	logic [MEM_ADDR_W-1:0] word_addr;
	logic [MEM_ADDR_W-1:0] after_col;
	logic [MEM_ADDR_W-1:0] after_row;

	always_comb begin
		col_bits = SDR_COL_BASE + int'(map.col_code);
		row_bits = ROW_BASE + int'(map.row_code);
		// Byte lane bits never reach the column lines
		word_addr = map.addr >> BYTE_OFS_W;
		after_col = word_addr >> col_bits;
		after_row = after_col >> row_bits;
		map.col = COL_W'(word_addr & field_mask(col_bits));
		map.row = ROW_W'(after_col & field_mask(row_bits));
		// Upper decoded bank bit lands on bank line 1
		map.bank = after_row[BANK_W-1:0];
	end

endmodule

// >>> design/sdram_cmd_mode_refresh_map.sv
// Register file, command-mode sequencer and refresh timer of the SDRAM controller
module sdram_cmd_mode_refresh_map
	import sdram_ctrl_pkg::*;
#(
	parameter int SYNC_STAGES = 3
) (
	input  wire logic                  clk_i,
	input  wire logic                  sys_rst_i,
	// APB slave
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [ADDR_W-1:0]     paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic      [31:0]           prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	// Memory access port, timed by its own clock
	input  wire logic                  mem_clk_i,
	input  wire logic                  acc_valid_i,
	input  wire logic                  acc_write_i,
	input  wire logic [MEM_ADDR_W-1:0] acc_addr_i,
	// Command outputs to the memory
	output logic                       cmd_valid_o,
	output logic      [CMD_W-1:0]      cmd_o,
	output logic      [BANK_W-1:0]     bank_field_o,
	output logic      [ROW_W-1:0]      mem_addr_o,
	output logic      [BYTE_OFS_W-1:0] byte_ofs_o,
	output logic                       acc_done_o,
	output logic                       refresh_pulse_o
);

	localparam int PIPE_W = 2 + MEM_ADDR_W;

	function automatic logic locked_offset(input logic [ADDR_W-1:0] ofs);
		locked_offset = (ofs == OFS_COMMAND_MODE_SELECT) || (ofs == OFS_REFRESH_INTERVAL) ||
			(ofs == OFS_MEMORY_GEOMETRY_CONFIG);
	endfunction

	function automatic logic mapped_offset(input logic [ADDR_W-1:0] ofs);
		case (ofs)
			OFS_COMMAND_MODE_SELECT, OFS_REFRESH_INTERVAL, OFS_MEMORY_GEOMETRY_CONFIG,
			OFS_TIMING_PARAMS_A, OFS_TIMING_PARAMS_B, OFS_TIMING_PARAMS_C,
			OFS_POWER_SAVING_CONFIG, OFS_MEMORY_TYPE_SELECT, OFS_DELAY_LOOP_INFO,
			OFS_FAST_ACCESS_CONFIG, OFS_WRITE_LOCK_CONTROL,
			OFS_WRITE_LOCK_VIOLATION_INFO: mapped_offset = 1'b1;
			default: mapped_offset = 1'b0;
		endcase
	endfunction

	// Registers
	logic [MODE_W-1:0]  mode_q;
	logic [COUNT_W-1:0] count_q;
	logic [31:0]        geom_q;
	logic [31:0]        tpa_q;
	logic [31:0]        tpb_q;
	logic [31:0]        tpc_q;
	logic [31:0]        lpr_q;
	logic [31:0]        mtype_q;
	logic [31:0]        hs_q;
	logic               lock_en_q;
	logic               viol_q;
	logic [ADDR_W-1:0]  viol_src_q;

	// APB decode
	logic setup_phase;
	logic wr_access;
	logic rd_access;
	logic wr_blocked;
	logic wr_ok;

	assign setup_phase = psel_i && !penable_i;
	assign wr_access = psel_i && penable_i && pwrite_i && mapped_offset(paddr_i);
	assign rd_access = psel_i && penable_i && !pwrite_i;
	assign wr_blocked = wr_access && lock_en_q && locked_offset(paddr_i);
	assign wr_ok = wr_access && !wr_blocked;

	// Zero-wait APB: answer assembled in setup, presented in access
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= setup_phase;
			pslverr_o <= setup_phase && !mapped_offset(paddr_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (setup_phase && !pwrite_i) begin
			case (paddr_i)
				OFS_COMMAND_MODE_SELECT: prdata_o <= 32'(mode_q);
				OFS_REFRESH_INTERVAL: prdata_o <= 32'(count_q);
				OFS_MEMORY_GEOMETRY_CONFIG: prdata_o <= geom_q;
				OFS_TIMING_PARAMS_A: prdata_o <= tpa_q;
				OFS_TIMING_PARAMS_B: prdata_o <= tpb_q;
				OFS_TIMING_PARAMS_C: prdata_o <= tpc_q;
				OFS_POWER_SAVING_CONFIG: prdata_o <= lpr_q;
				OFS_MEMORY_TYPE_SELECT: prdata_o <= mtype_q;
				OFS_DELAY_LOOP_INFO: prdata_o <= RST_DELAY_LOOP_INFO;
				OFS_FAST_ACCESS_CONFIG: prdata_o <= hs_q;
				OFS_WRITE_LOCK_CONTROL: prdata_o <= 32'(lock_en_q) << LOCK_EN_BIT;
				OFS_WRITE_LOCK_VIOLATION_INFO: begin
					prdata_o <= (32'(viol_q) << VIOL_BIT) | (32'(viol_src_q) << VIOL_SRC_LSB);
				end
				default: prdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// Lock-protected registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mode_q <= RST_COMMAND_MODE_SELECT[MODE_LSB +: MODE_W];
			count_q <= RST_REFRESH_INTERVAL[COUNT_LSB +: COUNT_W];
			geom_q <= RST_MEMORY_GEOMETRY_CONFIG;
		end else if (wr_ok) begin
			case (paddr_i)
				OFS_COMMAND_MODE_SELECT: mode_q <= pwdata_i[MODE_LSB +: MODE_W];
				OFS_REFRESH_INTERVAL: count_q <= pwdata_i[COUNT_LSB +: COUNT_W];
				OFS_MEMORY_GEOMETRY_CONFIG: geom_q <= pwdata_i;
				default: ;
			endcase
		end
	end

	// Storage-only registers and the write-lock enable; the storage ones drive no logic or output and are only read back
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tpa_q <= RST_TIMING_PARAMS_A;
			tpb_q <= RST_TIMING_PARAMS_B;
			tpc_q <= RST_TIMING_PARAMS_C;
			lpr_q <= RST_POWER_SAVING_CONFIG;
			mtype_q <= RST_MEMORY_TYPE_SELECT;
			hs_q <= RST_FAST_ACCESS_CONFIG;
			lock_en_q <= RST_WRITE_LOCK_CONTROL[LOCK_EN_BIT];
		end else if (wr_ok) begin
			case (paddr_i)
				OFS_TIMING_PARAMS_A: tpa_q <= pwdata_i;
				OFS_TIMING_PARAMS_B: tpb_q <= pwdata_i;
				OFS_TIMING_PARAMS_C: tpc_q <= pwdata_i;
				OFS_POWER_SAVING_CONFIG: lpr_q <= pwdata_i;
				OFS_MEMORY_TYPE_SELECT: mtype_q <= pwdata_i;
				OFS_FAST_ACCESS_CONFIG: hs_q <= pwdata_i;
				OFS_WRITE_LOCK_CONTROL: lock_en_q <= pwdata_i[LOCK_EN_BIT];
				default: ;
			endcase
		end
	end

	// Violation flag clears on read; a new violation in that cycle wins
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			viol_q <= 1'b0;
			viol_src_q <= '0;
		end else if (wr_blocked) begin
			viol_q <= 1'b1;
			viol_src_q <= paddr_i;
		end else if (rd_access && paddr_i == OFS_WRITE_LOCK_VIOLATION_INFO) begin
			viol_q <= 1'b0;
			viol_src_q <= '0;
		end
	end

	// Memory clock and access fields: three stages, change taken once 2 and 3 agree
	logic [SYNC_STAGES-1:0] mclk_sync_q;
	logic [PIPE_W-1:0]      acc_pipe_q [SYNC_STAGES];
	logic                   mclk_level_q;
	logic                   mclk_rise;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mclk_sync_q <= '0;
		end else begin
			mclk_sync_q <= {mclk_sync_q[SYNC_STAGES-2:0], mem_clk_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < SYNC_STAGES; i++) begin
				acc_pipe_q[i] <= '0;
			end
		end else begin
			acc_pipe_q[0] <= {acc_valid_i, acc_write_i, acc_addr_i};
			for (int i = 1; i < SYNC_STAGES; i++) begin
				acc_pipe_q[i] <= acc_pipe_q[i-1];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mclk_level_q <= 1'b0;
		end else if (mclk_sync_q[SYNC_STAGES-1] == mclk_sync_q[SYNC_STAGES-2]) begin
			mclk_level_q <= mclk_sync_q[SYNC_STAGES-1];
		end
	end

	assign mclk_rise = (mclk_sync_q[SYNC_STAGES-1] == mclk_sync_q[SYNC_STAGES-2]) &&
		mclk_sync_q[SYNC_STAGES-1] && !mclk_level_q;

	logic                  acc_seen;
	logic                  acc_wr_s;
	logic [MEM_ADDR_W-1:0] acc_addr_s;
	assign acc_seen = mclk_rise && acc_pipe_q[SYNC_STAGES-1][PIPE_W-1];
	assign acc_wr_s = acc_pipe_q[SYNC_STAGES-1][PIPE_W-2];
	assign acc_addr_s = acc_pipe_q[SYNC_STAGES-1][MEM_ADDR_W-1:0];

	// Refresh timer; a zero count keeps it stopped
	logic [COUNT_W-1:0] timer_q;
	logic               refresh_due_q;
	logic               refresh_tick;
	logic               refresh_taken;
	assign refresh_tick = (count_q != '0) && (timer_q == '0);
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			timer_q <= '0;
		end else if (count_q == '0 || refresh_tick) begin
			timer_q <= count_q;
		end else begin
			timer_q <= timer_q - COUNT_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			refresh_pulse_o <= 1'b0;
		end else begin
			refresh_pulse_o <= refresh_tick;
		end
	end

	// Pending refresh survives a taken-in-same-cycle tick
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			refresh_due_q <= 1'b0;
		end else if (refresh_tick) begin
			refresh_due_q <= 1'b1;
		end else if (refresh_taken) begin
			refresh_due_q <= 1'b0;
		end
	end

	// Deep power-down is entered on the mode write itself, not on an access
	logic dpd_req_q;
	logic dpd_set;
	logic dpd_taken;
	assign dpd_set = wr_ok && paddr_i == OFS_COMMAND_MODE_SELECT &&
		pwdata_i[MODE_LSB +: MODE_W] == MODE_DEEP_POWER_DOWN;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			dpd_req_q <= 1'b0;
		end else if (dpd_set) begin
			dpd_req_q <= 1'b1;
		end else if (dpd_taken) begin
			dpd_req_q <= 1'b0;
		end
	end

	// Address split
	addr_map_if map_bus ();
	assign map_bus.addr = acc_addr_s;
	assign map_bus.col_code = geom_q[COL_CODE_LSB +: GEOM_CODE_W];
	assign map_bus.row_code = geom_q[ROW_CODE_LSB +: GEOM_CODE_W];
	sdr32_addr_mapper u_mapper (
		.map (map_bus)
	);

	// Command sequencer
	seq_state_t            state_q;
	logic                  pend_wr_q;
	logic [COL_W-1:0]      pend_col_q;
	logic                  seq_idle;
	assign seq_idle = (state_q == ST_IDLE);
	assign dpd_taken = seq_idle && dpd_req_q;
	// Refresh only interleaves with normal decoding; init modes belong to software
	assign refresh_taken = seq_idle && !dpd_req_q && refresh_due_q && mode_q == MODE_NORMAL;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q <= ST_IDLE;
			pend_wr_q <= 1'b0;
			pend_col_q <= '0;
			cmd_valid_o <= 1'b0;
			cmd_o <= CMD_NOP;
			bank_field_o <= '0;
			mem_addr_o <= '0;
			byte_ofs_o <= '0;
			acc_done_o <= 1'b0;
		end else begin
			cmd_valid_o <= 1'b0;
			acc_done_o <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (dpd_taken) begin
						cmd_valid_o <= 1'b1;
						cmd_o <= CMD_DEEP_POWER_DOWN;
					end else if (refresh_taken) begin
						// Banks closed first so the refresh is legal
						cmd_valid_o <= 1'b1;
						cmd_o <= CMD_PRECHARGE_ALL;
						state_q <= ST_REFRESH;
					end else if (acc_seen) begin
						cmd_valid_o <= 1'b1;
						bank_field_o <= map_bus.bank;
						mem_addr_o <= map_bus.row;
						byte_ofs_o <= acc_addr_s[BYTE_OFS_W-1:0];
						// Only normal decoding needs a second command before done
						acc_done_o <= (mode_q != MODE_NORMAL);
						case (mode_q)
							MODE_NORMAL: begin
								cmd_o <= CMD_ACTIVATE;
								pend_wr_q <= acc_wr_s;
								pend_col_q <= map_bus.col;
								state_q <= ST_DATA;
							end
							MODE_NOP: cmd_o <= CMD_NOP;
							MODE_PRECHARGE_ALL: cmd_o <= CMD_PRECHARGE_ALL;
							MODE_LOAD_MODE: cmd_o <= CMD_LOAD_MODE;
							MODE_AUTO_REFRESH: cmd_o <= CMD_AUTO_REFRESH;
							// Bank lines carry the target chosen by the access address
							MODE_EXT_LOAD_MODE: cmd_o <= CMD_EXT_LOAD_MODE;
							default: begin
								// Powered down or reserved: no command, last code kept
								cmd_valid_o <= 1'b0;
							end
						endcase
					end
				end
				ST_DATA: begin
					cmd_valid_o <= 1'b1;
					cmd_o <= pend_wr_q ? CMD_WRITE : CMD_READ;
					mem_addr_o <= ROW_W'(pend_col_q);
					acc_done_o <= 1'b1;
					state_q <= ST_IDLE;
				end
				ST_REFRESH: begin
					cmd_valid_o <= 1'b1;
					cmd_o <= CMD_AUTO_REFRESH;
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

endmodule

// >>> verif/sdram_cmd_mode_refresh_map_monitor.sv
// Port checker for the register handshake and command ordering
module sdram_cmd_mode_refresh_map_monitor
	import sdram_ctrl_pkg::*;
(
	input wire logic             clk_i,
	input wire logic             sys_rst_i,
	input wire logic             psel_i,
	input wire logic             penable_i,
	input wire logic             pready_o,
	input wire logic             pslverr_o,
	input wire logic             cmd_valid_o,
	input wire logic [CMD_W-1:0] cmd_o,
	input wire logic             acc_done_o,
	input wire logic             refresh_pulse_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence s_act;
		cmd_valid_o && cmd_o == CMD_ACTIVATE;
	endsequence
	sequence s_col;
		cmd_valid_o && acc_done_o && (cmd_o == CMD_READ || cmd_o == CMD_WRITE);
	endsequence

	chk_ready_after_setup: assert property (
		psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
	chk_ready_in_access: assert property (
		pready_o |-> psel_i && penable_i ##1 !pready_o) else $error("ready misplaced");
	chk_error_with_ready: assert property (
		pslverr_o |-> pready_o) else $error("error without ready");
	chk_column_after_act: assert property (
		s_act |=> s_col) else $error("no column command after activate");
	chk_column_has_act: assert property (
		s_col |-> $past(cmd_valid_o) && $past(cmd_o) == CMD_ACTIVATE)
		else $error("column command without activate");
	chk_timer_refresh_order: assert property (
		cmd_valid_o && cmd_o == CMD_AUTO_REFRESH && !acc_done_o
		|-> $past(cmd_valid_o) && $past(cmd_o) == CMD_PRECHARGE_ALL)
		else $error("timer refresh without precharge");
	chk_refresh_pulse_one: assert property (
		refresh_pulse_o |=> !refresh_pulse_o) else $error("refresh pulse too long");
	chk_done_pulse_one: assert property (
		acc_done_o |=> !acc_done_o) else $error("done pulse too long");
	chk_cmd_holds: assert property (
		!cmd_valid_o |-> $stable(cmd_o)) else $error("command changed while idle");
endmodule

bind sdram_cmd_mode_refresh_map sdram_cmd_mode_refresh_map_monitor u_sdram_cmd_mode_refresh_map_monitor (
	.clk_i(clk_i),
	.sys_rst_i(sys_rst_i),
	.psel_i(psel_i),
	.penable_i(penable_i),
	.pready_o(pready_o),
	.pslverr_o(pslverr_o),
	.cmd_valid_o(cmd_valid_o),
	.cmd_o(cmd_o),
	.acc_done_o(acc_done_o),
	.refresh_pulse_o(refresh_pulse_o)
);

// >>> verif/sdram_device_model.sv
// Behavioural memory device that logs the commands it receives
module sdram_device_model
	import sdram_ctrl_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              cmd_valid_i,
	input  wire logic [CMD_W-1:0]  cmd_i,
	input  wire logic [BANK_W-1:0] bank_i,
	input  wire logic [ROW_W-1:0]  addr_i,
	output int                     n_cmd_o,
	output logic      [CMD_W-1:0]  last_cmd_o,
	output logic      [BANK_W-1:0] last_bank_o,
	output logic      [ROW_W-1:0]  last_addr_o,
	output logic      [ROW_W-1:0]  open_row_o,
	output logic                   order_err_o
);
	// Banks start idle after power-up
	logic closed_q = 1'b1;

	initial begin
		n_cmd_o = 0;
		order_err_o = 1'b0;
	end

	always @(posedge clk_i) begin
		if (cmd_valid_i) begin
			n_cmd_o <= n_cmd_o + 1;
			last_cmd_o <= cmd_i;
			last_bank_o <= bank_i;
			last_addr_o <= addr_i;
			if (cmd_i == CMD_ACTIVATE) begin
				open_row_o <= addr_i;
				closed_q <= 1'b0;
			end
			if (cmd_i == CMD_PRECHARGE_ALL)
				closed_q <= 1'b1;
			// Refresh into an open bank would lose its row
			if (cmd_i == CMD_AUTO_REFRESH && !closed_q)
				order_err_o <= 1'b1;
		end
	end
endmodule

// >>> verif/sdram_cmd_mode_refresh_map_tb.sv
// Bench: registers, write lock, address mapping, command modes, refresh
module sdram_cmd_mode_refresh_map_tb import sdram_ctrl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [ADDR_W-1:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0;
	logic mem_clk_i = 1'b0;
	logic acc_valid_i = 1'b0;
	logic acc_write_i = 1'b0;
	logic [MEM_ADDR_W-1:0] acc_addr_i = '0;
	logic [31:0] prdata_o, rd, seed = 32'h1DEC3E46;
	logic pready_o, pslverr_o, cmd_valid_o, acc_done_o, refresh_pulse_o, err, dev_err;
	logic [CMD_W-1:0] cmd_o, dev_cmd;
	logic [BANK_W-1:0] bank_field_o, dev_bank;
	logic [ROW_W-1:0] mem_addr_o, dev_addr, dev_row;
	logic [BYTE_OFS_W-1:0] byte_ofs_o;
	int n_cmd, cnt, k;
	int n_fail = 0;
	int tests_run = 0;
	logic [7:0] rst_ofs [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20,
		8'h24, 8'h2C, 8'hE4, 8'hE8};
	logic [31:0] rst_val [12] = '{32'h0, 32'h0, 32'h7024, 32'h20227225, 32'h3C80808,
		32'h2062, 32'h10000, 32'h10, 32'h1, 32'h0, 32'h0, 32'h0};
	logic [CMD_W-1:0] mode_cmd [5] = '{CMD_NOP, CMD_PRECHARGE_ALL, CMD_LOAD_MODE,
		CMD_AUTO_REFRESH, CMD_EXT_LOAD_MODE};

	always #50 clk_i = ~clk_i;
	// Access clock offset so its edges never line up with clk_i
	initial begin
		#37;
		forever #400 mem_clk_i = ~mem_clk_i;
	end

	sdram_cmd_mode_refresh_map u_sdram_cmd_mode_refresh_map (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .mem_clk_i(mem_clk_i), .acc_valid_i(acc_valid_i),
		.acc_write_i(acc_write_i), .acc_addr_i(acc_addr_i), .cmd_valid_o(cmd_valid_o),
		.cmd_o(cmd_o), .bank_field_o(bank_field_o), .mem_addr_o(mem_addr_o),
		.byte_ofs_o(byte_ofs_o), .acc_done_o(acc_done_o), .refresh_pulse_o(refresh_pulse_o));

	sdram_device_model u_sdram_device_model (.clk_i(clk_i), .cmd_valid_i(cmd_valid_o),
		.cmd_i(cmd_o), .bank_i(bank_field_o), .addr_i(mem_addr_o), .n_cmd_o(n_cmd),
		.last_cmd_o(dev_cmd), .last_bank_o(dev_bank), .last_addr_o(dev_addr),
		.open_row_o(dev_row), .order_err_o(dev_err));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
		tests_run++;
		if (seen !== expv) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, expv, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			if (pready_o === 1'b1) break;
		end
		check("pready", pready_o, 1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// Valid is held until done so a whole access-clock period is covered
	task automatic access(input logic w, input logic [27:0] a, input int cmds);
		int c0;
		c0 = n_cmd;
		@(posedge clk_i);
		acc_valid_i <= 1'b1;
		acc_write_i <= w;
		acc_addr_i <= a;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk_i);
			if (acc_done_o === 1'b1) break;
		end
		acc_valid_i <= 1'b0;
		check("acc_done", acc_done_o, 1);
		check("byte_ofs", byte_ofs_o, a[1:0]);
		@(posedge clk_i);
		check("cmd_count", n_cmd - c0, cmds);
	endtask

	task automatic map_test(input int nc, input int nr, input logic w, input logic [27:0] a);
		int cb, rb;
		cb = SDR_COL_BASE + nc;
		rb = ROW_BASE + nr;
		apb(1, OFS_MEMORY_GEOMETRY_CONFIG, (RST_MEMORY_GEOMETRY_CONFIG & 32'hFFFF_FFF0)
			| (nr << ROW_CODE_LSB) | nc);
		access(w, a, 2);
		check("col", dev_addr, (a >> 2) & ((1 << cb) - 1));
		check("row", dev_row, (a >> (2 + cb)) & ((1 << rb) - 1));
		check("bank", dev_bank, (a >> (2 + cb + rb)) & 3);
		check("rw_cmd", dev_cmd, w ? CMD_WRITE : CMD_READ);
	endtask

	task automatic wait_pulse(output int n);
		for (n = 1; n < 100; n++) begin
			@(posedge clk_i);
			if (refresh_pulse_o === 1'b1) break;
		end
	endtask

	initial begin
		#1_000_000;
		n_fail++;
		finish_test();
	end

	initial begin
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		foreach (rst_ofs[i]) begin
			apb(0, rst_ofs[i], 0);
			check("reset_value", rd, rst_val[i]);
			check("slverr_ok", err, 0);
		end
		apb(0, 8'h18, 0);
		check("unmapped_err", err, 1);
		check("unmapped_data", rd, 0);
		apb(1, OFS_DELAY_LOOP_INFO, 32'hFFFF_FFFF);
		apb(0, OFS_DELAY_LOOP_INFO, 0);
		check("read_only", rd, RST_DELAY_LOOP_INFO);
		$display("test registers done");
		for (int nr = 0; nr < 4; nr++)
			for (int nc = 0; nc < 4; nc++) begin
				seed = lfsr(seed);
				map_test(nc, nr, seed[31], seed[27:0]);
			end
		$display("test mapping done");
		// Back to 11 columns, 13 rows: bank sits in address bits 27:26
		apb(1, OFS_MEMORY_GEOMETRY_CONFIG, (RST_MEMORY_GEOMETRY_CONFIG & 32'hFFFF_FFF0)
			| (2 << ROW_CODE_LSB) | 3);
		foreach (mode_cmd[m]) begin
			seed = lfsr(seed);
			apb(1, OFS_COMMAND_MODE_SELECT, m + 1);
			access(1'b1, seed[27:0], 1);
			check("mode_cmd", dev_cmd, mode_cmd[m]);
			if (m == 4)
				check("mode_bank", dev_bank, seed[27:26]);
		end
		check("refresh_order", dev_err, 0);
		apb(1, OFS_COMMAND_MODE_SELECT, MODE_NORMAL);
		access(1'b1, seed[31:4], 2);
		$display("test modes done");
		apb(1, OFS_WRITE_LOCK_CONTROL, 1);
		apb(1, OFS_COMMAND_MODE_SELECT, MODE_NOP);
		apb(1, OFS_REFRESH_INTERVAL, 32'h55);
		apb(0, OFS_WRITE_LOCK_VIOLATION_INFO, 0);
		check("viol_info", rd, {16'h0, OFS_REFRESH_INTERVAL, 8'h01});
		apb(0, OFS_WRITE_LOCK_VIOLATION_INFO, 0);
		check("viol_clear", rd, 0);
		apb(0, OFS_COMMAND_MODE_SELECT, 0);
		check("locked_mode", rd, MODE_NORMAL);
		apb(0, OFS_REFRESH_INTERVAL, 0);
		check("locked_count", rd, 0);
		apb(1, OFS_WRITE_LOCK_CONTROL, 0);
		$display("test lock done");
		seed = lfsr(seed);
		cnt = 8 + seed[3:0];
		apb(1, OFS_REFRESH_INTERVAL, cnt);
		apb(0, OFS_REFRESH_INTERVAL, 0);
		check("count_rw", rd, cnt);
		wait_pulse(k);
		wait_pulse(k);
		check("refresh_period", k, cnt + 1);
		repeat (4) @(posedge clk_i);
		check("refresh_cmd", dev_cmd, CMD_AUTO_REFRESH);
		check("refresh_order", dev_err, 0);
		// Count as software plans it: 10 000 cycles per ms, 13 row bits
		cnt = REFRESH_PERIOD_MS * 10_000 / (1 << (ROW_BASE + 2));
		apb(1, OFS_REFRESH_INTERVAL, cnt);
		apb(0, OFS_REFRESH_INTERVAL, 0);
		check("count_plan", rd, cnt);
		apb(1, OFS_REFRESH_INTERVAL, 0);
		$display("test refresh done");
		apb(1, OFS_COMMAND_MODE_SELECT, MODE_DEEP_POWER_DOWN);
		repeat (4) @(posedge clk_i);
		check("deep_pd", dev_cmd, CMD_DEEP_POWER_DOWN);
		$display("test power down done");
		finish_test();
	end
endmodule
